// ==== rtl/citd_decoder.sv ====
// Purpose: instruction length and cycle timing decoder of the 8-bit core
// Assumes: program memory answers code_addr_out in the same cycle
// Notes: groups outside this block's set retire as 1 byte, 1 cycle
// Summary of operation
// - add, add-carry, sub-borrow with bank register: 1 byte, 1 cycle
// - accumulator arithmetic with direct byte: 2 bytes, 2 cycles
// - accumulator arithmetic via indirect pointer: 1 byte, 2 cycles
// - accumulator arithmetic with immediate: 2 bytes, 2 cycles
// - load data pointer: 3 bytes, 3 cycles; increment it: 1, 1
// - and/or/xor immediate into direct byte: 3 bytes, 3 cycles
// - and/or/xor accumulator into direct byte: 2 bytes, 2 cycles
// - and/or/xor bank register into accumulator: 1 byte, 1 cycle
// - clear, complement, rotates, nibble swap of accumulator: 1, 1
// - direct-to-direct or immediate-to-direct move: 3 bytes, 3 cycles
// - indirect RAM to direct byte move: 2 bytes, 2 cycles
// - accumulator to indirect RAM: 1 byte, 2 cycles
// - code byte read relative to pc or pointer: 1 byte, 3 cycles
// - every external data move: 1 byte, 3 cycles
// - push or pop of direct byte: 2 bytes, 2 cycles
// - low nibble exchange with indirect RAM: 1 byte, 2 cycles
// - exchange bank register with accumulator: 1 byte, 1 cycle
// - immediate into bank register: 2 bytes, 2 cycles
`timescale 1ns/100ps
`include "citd_defs.svh"
module citd_decoder (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // program memory
  input wire logic [7:0] code_data_in,
  output logic [15:0] code_addr_out,
  // pipeline control
  input wire logic hold_in,
  // retired instruction report
  output logic retire_out,
  output logic [15:0] instr_addr_out,
  output logic [7:0] opcode_out,
  output logic [7:0] operand1_out,
  output logic [7:0] operand2_out,
  output logic [1:0] length_out,
  output logic [1:0] cycles_out,
  output logic [3:0] form_out,
  output logic illegal_out
);

  citd_pkg::citd_state_e state_reg;
  citd_pkg::citd_state_e state_next;
  citd_pkg::citd_form_e form_c;
  citd_pkg::citd_form_e form_reg;
  logic [15:0] pc_reg;
  logic [15:0] code_addr_reg;
  logic [1:0] len_c;
  logic [1:0] cyc_c;
  logic ill_c;
  logic [1:0] len_reg;
  logic [1:0] cyc_reg;
  logic ill_reg;
  logic [1:0] cyc_idx;
  logic [7:0] opcode_hold;
  logic [7:0] op1_hold;
  logic [7:0] op2_hold;
  logic [3:0] grp;
  logic [3:0] mode;
  logic in_decode;
  logic advance;
  logic retire_now;
  logic [1:0] len_now;
  logic [1:0] cyc_now;
  logic [15:0] next_pc;
  logic op1_live;
  logic op2_live;
  logic retire_reg;
  logic [15:0] instr_addr_reg;
  logic [7:0] opcode_reg;
  logic [7:0] operand1_reg;
  logic [7:0] operand2_reg;
  logic [1:0] length_reg;
  logic [1:0] cycles_reg;
  logic illegal_reg;

  assign grp = code_data_in[7:4];
  assign mode = code_data_in[3:0];
  assign in_decode = (state_reg == citd_pkg::ST_DECODE);
  // a held cycle counts as no cycle at all; memory may still be busy
  assign advance = !hold_in;

  // length and timing of the opcode on the code bus
  always_comb
  begin
    len_c = `CITD_LEN_1;
    cyc_c = `CITD_CYC_1;
    form_c = citd_pkg::FORM_ILLEGAL;
    ill_c = 1'b0;
    case (grp)
      `CITD_GRP_ADD, `CITD_GRP_ADD_CARRY, `CITD_GRP_SUB_BORROW,
      `CITD_GRP_AND, `CITD_GRP_OR, `CITD_GRP_XOR, `CITD_GRP_MOV_TO_ACC:
      begin
        if (!mode[3])
        begin
          len_c = `CITD_LEN_1;
          cyc_c = `CITD_CYC_1;
          form_c = citd_pkg::FORM_BANK;
        end
        else if (mode == `CITD_MODE_DIRECT)
        begin
          len_c = `CITD_LEN_2;
          cyc_c = `CITD_CYC_2;
          form_c = citd_pkg::FORM_DIRECT;
        end
        else if (mode == `CITD_MODE_IND0 || mode == `CITD_MODE_IND1)
        begin
          len_c = `CITD_LEN_1;
          cyc_c = `CITD_CYC_2;
          form_c = citd_pkg::FORM_INDIRECT;
        end
        else if (mode == `CITD_MODE_IMM)
        begin
          len_c = `CITD_LEN_2;
          cyc_c = `CITD_CYC_2;
          form_c = citd_pkg::FORM_IMMEDIATE;
        end
        else if (grp >= `CITD_GRP_AND && grp <= `CITD_GRP_XOR &&
                 mode == `CITD_MODE_DIR_ACC)
        begin
          len_c = `CITD_LEN_2;
          cyc_c = `CITD_CYC_2;
          form_c = citd_pkg::FORM_DIR_ACC;
        end
        else if (grp >= `CITD_GRP_AND && grp <= `CITD_GRP_XOR &&
                 mode == `CITD_MODE_DIR_IMM)
        begin
          len_c = `CITD_LEN_3;
          cyc_c = `CITD_CYC_3;
          form_c = citd_pkg::FORM_DIR_IMM;
        end
        else
          ill_c = 1'b1;
      end
      `CITD_GRP_EXCHANGE, `CITD_GRP_INCREMENT, `CITD_GRP_DECREMENT:
      begin
        if (!mode[3])
        begin
          len_c = `CITD_LEN_1;
          cyc_c = `CITD_CYC_1;
          form_c = citd_pkg::FORM_BANK;
        end
        else if (mode == `CITD_MODE_DIRECT)
        begin
          len_c = `CITD_LEN_2;
          cyc_c = `CITD_CYC_2;
          form_c = citd_pkg::FORM_DIRECT;
        end
        else if (mode == `CITD_MODE_IND0 || mode == `CITD_MODE_IND1)
        begin
          len_c = `CITD_LEN_1;
          cyc_c = `CITD_CYC_2;
          form_c = citd_pkg::FORM_INDIRECT;
        end
        else if (grp != `CITD_GRP_EXCHANGE && mode == `CITD_MODE_ACC)
        begin
          len_c = `CITD_LEN_1;
          cyc_c = `CITD_CYC_1;
          form_c = citd_pkg::FORM_ACC;
        end
        else
          ill_c = 1'b1;
      end
      `CITD_GRP_MOV_TO_BANK:
      begin
        // bit 3 picks the source: accumulator or direct byte
        if (!mode[3])
        begin
          len_c = `CITD_LEN_1;
          cyc_c = `CITD_CYC_1;
          form_c = citd_pkg::FORM_ACC;
        end
        else
        begin
          len_c = `CITD_LEN_2;
          cyc_c = `CITD_CYC_2;
          form_c = citd_pkg::FORM_DIRECT;
        end
      end
      `CITD_GRP_BANK_IMM_ACC:
      begin
        if (!mode[3])
        begin
          len_c = `CITD_LEN_2;
          cyc_c = `CITD_CYC_2;
          form_c = citd_pkg::FORM_IMMEDIATE;
        end
        else
        begin
          // clear, complement, four rotates, swap, decimal adjust
          len_c = `CITD_LEN_1;
          cyc_c = `CITD_CYC_1;
          form_c = citd_pkg::FORM_ACC;
        end
      end
      `CITD_GRP_MOV_TO_DIRECT:
      begin
        len_c = `CITD_LEN_2;
        cyc_c = `CITD_CYC_2;
        if (!mode[3])
          form_c = citd_pkg::FORM_BANK;
        else if (mode == `CITD_MODE_IND0 || mode == `CITD_MODE_IND1)
          form_c = citd_pkg::FORM_INDIRECT;
        else if (mode == `CITD_MODE_DIR_ACC)
          form_c = citd_pkg::FORM_DIR_ACC;
        else if (mode == `CITD_MODE_DIRECT)
        begin
          len_c = `CITD_LEN_3;
          cyc_c = `CITD_CYC_3;
          form_c = citd_pkg::FORM_DIR_DIR;
        end
        else if (mode == `CITD_MODE_DIR_IMM)
        begin
          len_c = `CITD_LEN_3;
          cyc_c = `CITD_CYC_3;
          form_c = citd_pkg::FORM_DIR_IMM;
        end
        else
          ill_c = 1'b1;
      end
      `CITD_GRP_INDIRECT:
      begin
        form_c = citd_pkg::FORM_INDIRECT;
        case (mode[3:1])
          `CITD_IND_FROM_ACC:
          begin
            len_c = `CITD_LEN_1;
            cyc_c = `CITD_CYC_2;
          end
          `CITD_IND_FROM_DIRECT, `CITD_IND_FROM_IMM:
          begin
            len_c = `CITD_LEN_2;
            cyc_c = `CITD_CYC_2;
          end
          `CITD_IND_EXT_READ, `CITD_IND_EXT_WRITE:
          begin
            len_c = `CITD_LEN_1;
            cyc_c = `CITD_CYC_3;
            form_c = citd_pkg::FORM_EXTERNAL;
          end
          `CITD_IND_NIBBLE_XCH:
          begin
            len_c = `CITD_LEN_1;
            cyc_c = `CITD_CYC_2;
          end
          default:
            ill_c = 1'b1;
        endcase
      end
      `CITD_GRP_MISC:
      begin
        case (mode)
          `CITD_MISC_DATA_POINTER_REG_INC:
          begin
            len_c = `CITD_LEN_1;
            cyc_c = `CITD_CYC_1;
            form_c = citd_pkg::FORM_DATA_POINTER_REG;
          end
          `CITD_MISC_DATA_POINTER_REG_LOAD:
          begin
            len_c = `CITD_LEN_3;
            cyc_c = `CITD_CYC_3;
            form_c = citd_pkg::FORM_DATA_POINTER_REG;
          end
          `CITD_MISC_CODE_DATA_POINTER_REG, `CITD_MISC_CODE_PC:
          begin
            len_c = `CITD_LEN_1;
            cyc_c = `CITD_CYC_3;
            form_c = citd_pkg::FORM_CODE_READ;
          end
          `CITD_MISC_EXT_RD_DATA_POINTER_REG, `CITD_MISC_EXT_WR_DATA_POINTER_REG:
          begin
            len_c = `CITD_LEN_1;
            cyc_c = `CITD_CYC_3;
            form_c = citd_pkg::FORM_EXTERNAL;
          end
          `CITD_MISC_PUSH, `CITD_MISC_POP:
          begin
            len_c = `CITD_LEN_2;
            cyc_c = `CITD_CYC_2;
            form_c = citd_pkg::FORM_STACK;
          end
          default:
            ill_c = 1'b1;
        endcase
      end
      default:
        ill_c = 1'b1;
    endcase
    // unknown codes are skipped as one byte so fetch never stalls
    if (ill_c)
    begin
      len_c = `CITD_LEN_1;
      cyc_c = `CITD_CYC_1;
      form_c = citd_pkg::FORM_ILLEGAL;
    end
  end

  // in the first cycle the table answers directly, later it is held
  assign len_now = in_decode ? len_c : len_reg;
  assign cyc_now = in_decode ? cyc_c : cyc_reg;
  assign retire_now = advance &&
    (in_decode ? (cyc_c == `CITD_CYC_1)
               : (cyc_idx == 2'(cyc_reg - 2'h1)));
  assign next_pc = 16'(pc_reg + {14'h0000, len_now});
  assign op1_live = !in_decode && (cyc_idx == 2'h1) &&
    (len_reg > `CITD_LEN_1);
  assign op2_live = !in_decode && (cyc_idx == 2'h2) &&
    (len_reg == `CITD_LEN_3);

  citd_cycle_counter #(
    .WIDTH(`CITD_COUNT_W)
  ) u_cycle_counter (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .clear_in(retire_now),
    .inc_in(advance),
    .count_out(cyc_idx)
  );

  citd_byte_reg #(
    .WIDTH(`CITD_OPERAND_W)
  ) u_opcode_hold (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .load_in(in_decode && advance),
    .data_in(code_data_in),
    .data_out(opcode_hold)
  );

  citd_byte_reg #(
    .WIDTH(`CITD_OPERAND_W)
  ) u_op1_hold (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .load_in(op1_live && advance),
    .data_in(code_data_in),
    .data_out(op1_hold)
  );

  citd_byte_reg #(
    .WIDTH(`CITD_OPERAND_W)
  ) u_op2_hold (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .load_in(op2_live && advance),
    .data_in(code_data_in),
    .data_out(op2_hold)
  );

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      citd_pkg::ST_DECODE:
        if (advance && !retire_now)
          state_next = citd_pkg::ST_EXEC;
      citd_pkg::ST_EXEC:
        if (retire_now)
          state_next = citd_pkg::ST_DECODE;
      default:
        state_next = citd_pkg::ST_DECODE;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      state_reg <= citd_pkg::ST_DECODE;
    else
      state_reg <= state_next;
  end

  // decoded timing held for the remaining cycles
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      len_reg <= `CITD_LEN_1;
      cyc_reg <= `CITD_CYC_1;
      ill_reg <= 1'b0;
      form_reg <= citd_pkg::FORM_ILLEGAL;
    end
    else if (in_decode && advance)
    begin
      len_reg <= len_c;
      cyc_reg <= cyc_c;
      ill_reg <= ill_c;
      form_reg <= form_c;
    end
  end

  // fetch address walks the bytes, then parks until the last cycle
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pc_reg <= `CITD_RESET_ADDR;
      code_addr_reg <= `CITD_RESET_ADDR;
    end
    else if (retire_now)
    begin
      pc_reg <= next_pc;
      code_addr_reg <= next_pc;
    end
    else if (advance && (3'({1'b0, cyc_idx}) + 3'h1 < {1'b0, len_now}))
      code_addr_reg <= 16'(code_addr_reg + 16'h0001);
  end

  // report registers; a byte arriving in the retire cycle is taken live
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      retire_reg <= 1'b0;
      instr_addr_reg <= `CITD_RESET_ADDR;
      opcode_reg <= 8'h00;
      operand1_reg <= 8'h00;
      operand2_reg <= 8'h00;
      length_reg <= 2'h0;
      cycles_reg <= 2'h0;
      illegal_reg <= 1'b0;
    end
    else
    begin
      retire_reg <= retire_now;
      if (retire_now)
      begin
        instr_addr_reg <= pc_reg;
        opcode_reg <= in_decode ? code_data_in : opcode_hold;
        operand1_reg <= op1_live ? code_data_in :
          (!in_decode && len_reg > `CITD_LEN_1) ? op1_hold : 8'h00;
        operand2_reg <= op2_live ? code_data_in :
          (!in_decode && len_reg == `CITD_LEN_3) ? op2_hold : 8'h00;
        length_reg <= len_now;
        cycles_reg <= cyc_now;
        illegal_reg <= in_decode ? ill_c : ill_reg;
      end
    end
  end

  // form code held with the other report fields
  logic [3:0] form_out_reg;
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      form_out_reg <= 4'hF;
    else if (retire_now)
      form_out_reg <= in_decode ? form_c : form_reg;
  end

  assign code_addr_out = code_addr_reg;
  assign retire_out = retire_reg;
  assign instr_addr_out = instr_addr_reg;
  assign opcode_out = opcode_reg;
  assign operand1_out = operand1_reg;
  assign operand2_out = operand2_reg;
  assign length_out = length_reg;
  assign cycles_out = cycles_reg;
  assign form_out = form_out_reg;
  assign illegal_out = illegal_reg;

endmodule : citd_decoder

// ==== rtl/citd_defs.svh ====
// Purpose: opcode map, length and cycle constants of the timing decoder
// Assumes: included by bare name from the design files
// Notes: operation group in opcode[7:4], operand mode in opcode[3:0]
`ifndef CITD_DEFS_SVH
`define CITD_DEFS_SVH

`define CITD_RESET_ADDR 16'h0000
`define CITD_OPERAND_W 8
`define CITD_COUNT_W 2

// operation groups, opcode[7:4]
`define CITD_GRP_ADD 4'h0
`define CITD_GRP_ADD_CARRY 4'h1
`define CITD_GRP_SUB_BORROW 4'h2
`define CITD_GRP_AND 4'h3
`define CITD_GRP_OR 4'h4
`define CITD_GRP_XOR 4'h5
`define CITD_GRP_MOV_TO_ACC 4'h6
`define CITD_GRP_EXCHANGE 4'h7
`define CITD_GRP_INCREMENT 4'h8
`define CITD_GRP_DECREMENT 4'h9
`define CITD_GRP_MOV_TO_BANK 4'hA
`define CITD_GRP_BANK_IMM_ACC 4'hB
`define CITD_GRP_MOV_TO_DIRECT 4'hC
`define CITD_GRP_INDIRECT 4'hD
`define CITD_GRP_MISC 4'hE

// operand modes, opcode[3:0]; 0..7 select a bank register
`define CITD_MODE_IND0 4'h8
`define CITD_MODE_IND1 4'h9
`define CITD_MODE_DIRECT 4'hA
`define CITD_MODE_IMM 4'hB
`define CITD_MODE_DIR_ACC 4'hC
`define CITD_MODE_DIR_IMM 4'hD
`define CITD_MODE_ACC 4'hE

// indirect group sub codes, opcode[3:1]; opcode[0] picks the pointer
`define CITD_IND_FROM_ACC 3'h0
`define CITD_IND_FROM_DIRECT 3'h1
`define CITD_IND_FROM_IMM 3'h2
`define CITD_IND_EXT_READ 3'h3
`define CITD_IND_EXT_WRITE 3'h4
`define CITD_IND_NIBBLE_XCH 3'h5

// misc group sub codes, opcode[3:0]
`define CITD_MISC_DATA_POINTER_REG_INC 4'h0
`define CITD_MISC_DATA_POINTER_REG_LOAD 4'h1
`define CITD_MISC_CODE_DATA_POINTER_REG 4'h2
`define CITD_MISC_CODE_PC 4'h3
`define CITD_MISC_EXT_RD_DATA_POINTER_REG 4'h4
`define CITD_MISC_EXT_WR_DATA_POINTER_REG 4'h5
`define CITD_MISC_PUSH 4'h6
`define CITD_MISC_POP 4'h7

// encoded lengths in bytes and execution times in clock cycles
`define CITD_LEN_1 2'h1
`define CITD_LEN_2 2'h2
`define CITD_LEN_3 2'h3
`define CITD_CYC_1 2'h1
`define CITD_CYC_2 2'h2
`define CITD_CYC_3 2'h3

`endif

// ==== rtl/citd_pkg.sv ====
// Purpose: types shared by the timing decoder files
// Assumes: nothing
// Notes: form codes are reported on form_out
package citd_pkg;

  typedef enum logic [1:0] {
    ST_DECODE = 2'b01,
    ST_EXEC = 2'b10
  } citd_state_e;

  typedef enum logic [3:0] {
    FORM_BANK = 4'h0,
    FORM_DIRECT = 4'h1,
    FORM_INDIRECT = 4'h2,
    FORM_IMMEDIATE = 4'h3,
    FORM_DIR_ACC = 4'h4,
    FORM_DIR_IMM = 4'h5,
    FORM_ACC = 4'h6,
    FORM_DIR_DIR = 4'h7,
    FORM_DATA_POINTER_REG = 4'h8,
    FORM_CODE_READ = 4'h9,
    FORM_EXTERNAL = 4'hA,
    FORM_STACK = 4'hB,
    FORM_ILLEGAL = 4'hF
  } citd_form_e;

endpackage : citd_pkg

// ==== rtl/citd_byte_reg.sv ====
// Purpose: loadable holding register for instruction bytes
// Assumes: single clock, asynchronous active-high reset
// Notes: clears to zero at reset
`timescale 1ns/100ps
module citd_byte_reg #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // data
  input wire logic load_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      data_out <= '0;
    else if (load_in)
      data_out <= data_in;
  end

endmodule : citd_byte_reg

// ==== rtl/citd_cycle_counter.sv ====
// Purpose: cycle index counter within one instruction
// Assumes: clear has priority over increment
// Notes: wraps at its width; the decoder never counts that far
`timescale 1ns/100ps
module citd_cycle_counter #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // control
  input wire logic clear_in,
  input wire logic inc_in,
  output logic [WIDTH-1:0] count_out
);

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      count_out <= '0;
    else if (clear_in)
      count_out <= '0;
    else if (inc_in)
      count_out <= WIDTH'(count_out + 1'b1);
  end

endmodule : citd_cycle_counter

// ==== test/citd_decoder_checker.sv ====
// Purpose: port-level timing checks of the instruction timing decoder
// Assumes: one clock, reset_in asynchronous and active high
// Notes: bound to citd_decoder below
`timescale 1ns/100ps
module citd_decoder_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // program memory
  input wire logic [7:0] code_data_in,
  input wire logic [15:0] code_addr_out,
  // pipeline control
  input wire logic hold_in,
  // retire report
  input wire logic retire_out,
  input wire logic [15:0] instr_addr_out,
  input wire logic [7:0] opcode_out,
  input wire logic [7:0] operand1_out,
  input wire logic [7:0] operand2_out,
  input wire logic [1:0] length_out,
  input wire logic [1:0] cycles_out,
  input wire logic [3:0] form_out,
  input wire logic illegal_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  // non-held cycles since the last retire, the execution time just ended
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  always_comb cnt_next = (retire_out ? 4'h0 : cnt_reg) + {3'h0, !hold_in};
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_next;

  sequence legal_retire_s;
    retire_out && !illegal_out;
  endsequence

  retire_spacing_a: assert property (
    retire_out |-> cnt_reg == {2'h0, cycles_out})
    else $error("retire spacing differs from cycle count");
  pc_advance_a: assert property (retire_out |->
    code_addr_out == instr_addr_out + {14'h0000, length_out})
    else $error("fetch address not advanced by length");
  addr_step_a: assert property (!hold_in |=>
    $stable(code_addr_out) ||
    code_addr_out == $past(code_addr_out) + 16'h0001)
    else $error("fetch address jumped");
  hold_freeze_a: assert property (hold_in |=>
    $stable(code_addr_out) && !retire_out)
    else $error("held cycle advanced the decoder");
  legal_timing_a: assert property (legal_retire_s |->
    cycles_out >= length_out && length_out != 2'h0)
    else $error("cycle count below byte length");
  report_stands_a: assert property (!retire_out |-> $stable(opcode_out)
    && $stable(instr_addr_out) && $stable(length_out) && $stable(cycles_out))
    else $error("report changed without retire");
  // illegal_out stands with the other report fields, so judge it at retire
  illegal_retire_a: assert property (retire_out && illegal_out |->
    form_out == 4'hF && length_out == 2'h1 && cycles_out == 2'h1)
    else $error("illegal report malformed");
  operand_zero_a: assert property (retire_out |->
    (length_out > 2'h1 || operand1_out == 8'h00) &&
    (length_out > 2'h2 || operand2_out == 8'h00))
    else $error("operand beyond length not zero");
endmodule : citd_decoder_checker

bind citd_decoder citd_decoder_checker u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .code_data_in(code_data_in),
  .code_addr_out(code_addr_out), .hold_in(hold_in),
  .retire_out(retire_out), .instr_addr_out(instr_addr_out),
  .opcode_out(opcode_out), .operand1_out(operand1_out),
  .operand2_out(operand2_out), .length_out(length_out),
  .cycles_out(cycles_out), .form_out(form_out), .illegal_out(illegal_out)
);

// ==== test/citd_prog_mem.sv ====
// Purpose: program memory seen by the decoder, answers in the same cycle
// Assumes: bench loads rom before each reset
// Notes: only 256 bytes; upper address bits are ignored
`timescale 1ns/100ps
module citd_prog_mem (
  // fetch port
  input wire logic [15:0] addr_in,
  output logic [7:0] data_out
);
  logic [7:0] rom [0:255];
  assign data_out = rom[addr_in[7:0]];
endmodule : citd_prog_mem

// ==== test/citd_decoder_tb_top.sv ====
// Purpose: self-checking bench of the instruction timing decoder
// Assumes: inputs change 1 ns after the rising clock edge
// Notes: table rows hold opcode, byte length, cycle count
`timescale 1ns/100ps
module citd_decoder_tb_top;
  logic clk_in, reset_in, hold_in, retire_out, illegal_out;
  logic [7:0] code_data_in, opcode_out, operand1_out, operand2_out;
  logic [15:0] code_addr_out, instr_addr_out;
  logic [1:0] length_out, cycles_out;
  logic [3:0] form_out;
  int n_errors = 0;
  int cmp_count = 0;
  localparam logic [15:0] TBL [0:51] = '{
    16'h0011, 16'h1311, 16'h2711, 16'h0A22, 16'h1A22, 16'h2A22,
    16'h0812, 16'h1912, 16'h2812, 16'h0B22, 16'h1B22, 16'h2B22,
    16'hE011, 16'hE133, 16'h3D33, 16'h4D33, 16'h5D33, 16'h3C22,
    16'h4C22, 16'h5C22, 16'h3111, 16'h4511, 16'h5711, 16'hB811,
    16'hB911, 16'hBA11, 16'hBB11, 16'hBC11, 16'hBD11, 16'hBE11,
    16'hCA33, 16'hCD33, 16'hC822, 16'hD012, 16'hD112, 16'hE213,
    16'hE313, 16'hD613, 16'hD713, 16'hD813, 16'hD913, 16'hE413,
    16'hE513, 16'hE622, 16'hE722, 16'hDA12, 16'hDB12, 16'h7011,
    16'h7711, 16'hB022, 16'hB722, 16'hF011};

  citd_decoder DUT (
    .clk_in(clk_in), .reset_in(reset_in), .code_data_in(code_data_in),
    .code_addr_out(code_addr_out), .hold_in(hold_in),
    .retire_out(retire_out), .instr_addr_out(instr_addr_out),
    .opcode_out(opcode_out), .operand1_out(operand1_out),
    .operand2_out(operand2_out), .length_out(length_out),
    .cycles_out(cycles_out), .form_out(form_out), .illegal_out(illegal_out)
  );
  citd_prog_mem pm (.addr_in(code_addr_out), .data_out(code_data_in));

  function automatic logic [7:0] opnd(input logic [15:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : opnd

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // loads rows lo..hi from address 0, resets, then checks every retire
  task automatic run_seq(input string nm, input int lo, input int hi,
    input int hold_n);
    logic [15:0] a;
    logic [7:0] op;
    logic [1:0] ln, cy;
    int gap, t;
    a = 16'h0000;
    for (int k = 0; k < 256; k++)
      pm.rom[k] = 8'hF0;
    for (int i = lo; i <= hi; i++)
    begin
      pm.rom[a[7:0]] = TBL[i][15:8];
      for (int b = 1; b < TBL[i][7:4]; b++)
        pm.rom[a[7:0] + b] = opnd(a + 16'(b));
      a = a + {12'h000, TBL[i][7:4]};
    end
    reset_in = 1'b1;
    hold_in = 1'b0;
    repeat (10) @(posedge clk_in);
    #1;
    chk("reset addr", 16'h0000, code_addr_out);
    chk("reset retire", 16'h0000, {15'h0000, retire_out});
    chk("reset form", 16'h000F, {12'h000, form_out});
    reset_in = 1'b0;
    a = 16'h0000;
    for (int i = lo; i <= hi; i++)
    begin
      op = TBL[i][15:8];
      ln = TBL[i][5:4];
      cy = TBL[i][1:0];
      gap = 0;
      t = 0;
      if (i == lo + 1 && hold_n > 0)
      begin
        hold_in = 1'b1;
        repeat (hold_n)
        begin
          @(posedge clk_in);
          #1;
          gap++;
          chk("held addr", a, code_addr_out);
        end
        hold_in = 1'b0;
      end
      do
      begin
        @(posedge clk_in);
        #1;
        gap++;
        t++;
      end
      while (retire_out !== 1'b1 && t < 12);
      chk("retire", 16'h0001, {15'h0000, retire_out});
      chk("instr addr", a, instr_addr_out);
      chk("opcode", {8'h00, op}, {8'h00, opcode_out});
      chk("operand1", {8'h00, ln > 2'h1 ? opnd(a + 16'h1) : 8'h00},
        {8'h00, operand1_out});
      chk("operand2", {8'h00, ln > 2'h2 ? opnd(a + 16'h2) : 8'h00},
        {8'h00, operand2_out});
      chk("length", {14'h0000, ln}, {14'h0000, length_out});
      chk("cycles", {14'h0000, cy}, {14'h0000, cycles_out});
      chk("illegal", {15'h0000, op[7:4] == 4'hF}, {15'h0000, illegal_out});
      if (i > lo)
        chk("spacing", 16'(cy) + 16'(i == lo + 1 ? hold_n : 0),
          16'(gap));
      a = a + {14'h0000, ln};
      chk("next pc", a, code_addr_out);
    end
    $display("test %s done", nm);
  endtask : run_seq

  task automatic test_arith();
    run_seq("arith", 0, 11, 0);
  endtask : test_arith

  task automatic test_logic();
    run_seq("logic", 14, 29, 0);
  endtask : test_logic

  task automatic test_xfer();
    run_seq("xfer", 30, 50, 0);
  endtask : test_xfer

  task automatic test_hold();
    run_seq("pointer hold", 12, 13, 2);
  endtask : test_hold

  task automatic test_illegal();
    run_seq("illegal", 49, 51, 0);
  endtask : test_illegal

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // the whole run needs well under 1000 cycles
  initial
  begin
    #20000;
    n_errors++;
    stop_test();
  end

  initial
  begin
    reset_in = 1'b1;
    hold_in = 1'b0;
    @(posedge clk_in);
    #1;
    test_arith();
    test_logic();
    test_xfer();
    test_hold();
    test_illegal();
    stop_test();
  end
endmodule : citd_decoder_tb_top
